/* File: verilog/vic_defs.vh */
`ifndef VIC_DEFS_VH
`define VIC_DEFS_VH

// Register offsets (byte addresses)
`define VIC_ADDR_W 8
`define VIC_OFS_CFG 8'h08
`define VIC_OFS_CTL 8'h0c

// Reset values
`define VIC_CFG_RST 13'h0000
`define VIC_EN_RST 4'h0
`define VIC_FLAG_RST 4'h0
`define VIC_RD_IDLE 32'h0000_0000
`define VIC_ACK_RST 1'b0
`define VIC_VEC_RST 8'h00

// No source selected
`define VIC_SRC_NONE 4'h0

// Configuration field positions
`define VIC_CFG_W 13
`define VIC_CFG_MODE 12
`define VIC_CFG_GEN 11
`define VIC_CFG_LVL_HI 10
`define VIC_CFG_LVL_LO 8
`define VIC_CFG_VEC_HI 7
`define VIC_CFG_VEC_LO 0

// Control field positions
`define VIC_NSRC 4
`define VIC_CTL_EN_LO 0
`define VIC_CTL_DIS_LO 16
`define VIC_CTL_CLR_LO 20
`define VIC_CTL_IRQ_ST 27
`define VIC_CTL_INT_ST 26
`define VIC_CTL_SRC_LO 28

// Source that never asserts
`define VIC_SRC_RESERVED 2

`endif

/* File: verilog/vic_vme_interrupter.v */
`timescale 1ns/1ps
// Notes on behaviour
// RULE_01 - Four sources; source 2 never asserts
// RULE_02 - Return 8-bit vector on low byte at acknowledge
// RULE_03 - Config bit 12 selects release mode
// RULE_04 - Register-access mode: pending until disable written
// RULE_05 - Acknowledge mode: ack clears flag, disables source
// RULE_06 - Master re-enables serviced source before reuse
// RULE_07 - Config bit 11 gates bus requests
// RULE_08 - Config bits 10:8 hold request level
// RULE_09 - Vector bit n drives data bit n
// RULE_10 - Config register at 0x8 reads back fields
// RULE_11 - Control bits 3:0 enable, read enable state
// RULE_12 - Control bits 19:16 disable, read zero
// RULE_13 - Control bits 23:20 clear flags, read flags
// RULE_14 - Bits 31:28 source status, 27 bus, 26 internal
// RULE_15 - Both registers zero after reset
// RULE_16 - Request is OR of enabled flags, gated
// RULE_17 - Enable with disable together: disable wins
`include "vic_defs.vh"

module vic_vme_interrupter (
  // Clock and reset
  input wire sys_clk,
  input wire reset,
  // Register port
  input wire [`VIC_ADDR_W-1:0] reg_addr,
  input wire reg_wr_en,
  input wire reg_rd_en,
  input wire [31:0] reg_wdata,
  output reg [31:0] reg_rdata_r,
  // Source conditions, same clock
  input wire [`VIC_NSRC-1:0] src_event,
  // Bus interrupt request
  output wire irq_req,
  output wire [2:0] irq_level,
  // Interrupt acknowledge cycle
  input wire iack_req,
  input wire [2:0] iack_level,
  output reg iack_ack_r,
  output reg iack_pass_r,
  output reg [7:0] iack_vector_r
);

  // ==========================================================
  // Stored state
  reg [`VIC_CFG_W-1:0] cfg_r;
  reg [`VIC_CFG_W-1:0] cfg_nxt;
  reg [`VIC_NSRC-1:0] en_r;
  reg [`VIC_NSRC-1:0] flag_r;
  wire [`VIC_NSRC-1:0] en_nxt;
  wire [`VIC_NSRC-1:0] flag_nxt;

  // ==========================================================
  // Address decode
  wire sel_cfg;
  wire sel_ctl;
  wire wr_cfg;
  wire wr_ctl;

  assign sel_cfg = (reg_addr == `VIC_OFS_CFG);
  assign sel_ctl = (reg_addr == `VIC_OFS_CTL);
  assign wr_cfg = reg_wr_en && sel_cfg;
  assign wr_ctl = reg_wr_en && sel_ctl;

  // ==========================================================
  // Configuration fields
  wire mode_ack;
  wire glb_en;
  wire [2:0] cfg_level;
  wire [7:0] cfg_vector;

  assign mode_ack = cfg_r[`VIC_CFG_MODE]; // RULE_03
  assign glb_en = cfg_r[`VIC_CFG_GEN]; // RULE_07
  assign cfg_level = cfg_r[`VIC_CFG_LVL_HI:`VIC_CFG_LVL_LO]; // RULE_08
  assign cfg_vector = cfg_r[`VIC_CFG_VEC_HI:`VIC_CFG_VEC_LO]; // RULE_09

  // ==========================================================
  // Control write strobes
  wire [`VIC_NSRC-1:0] w_en;
  wire [`VIC_NSRC-1:0] w_dis;
  wire [`VIC_NSRC-1:0] w_clr;

  assign w_en = wr_ctl ? reg_wdata[`VIC_CTL_EN_LO +: `VIC_NSRC] : `VIC_SRC_NONE; // RULE_11
  assign w_dis = wr_ctl ? reg_wdata[`VIC_CTL_DIS_LO +: `VIC_NSRC] : `VIC_SRC_NONE; // RULE_12
  assign w_clr = wr_ctl ? reg_wdata[`VIC_CTL_CLR_LO +: `VIC_NSRC] : `VIC_SRC_NONE; // RULE_13

  // ==========================================================
  // Request and acknowledge decode
  wire [`VIC_NSRC-1:0] src_st;
  wire int_req;
  wire bus_req;
  wire lvl_match;
  wire ack_hit;
  wire ack_miss;
  wire roak_ack;

  assign src_st = flag_r & en_r; // RULE_16
  assign int_req = |src_st; // RULE_16
  assign bus_req = int_req && glb_en; // RULE_07 RULE_16
  assign lvl_match = (iack_level == cfg_level);
  // Only a request that is up can be acknowledged
  assign ack_hit = iack_req && bus_req && lvl_match;
  assign ack_miss = iack_req && !ack_hit;
  assign roak_ack = ack_hit && mode_ack; // RULE_05

  assign irq_req = bus_req; // RULE_16
  assign irq_level = cfg_level; // RULE_08

  // ==========================================================
  // Per-source enable and flag
  genvar gi;
  generate
    for (gi = 0; gi < `VIC_NSRC; gi = gi + 1) begin : g_src
      wire ev;
      wire ack_src;
      wire en_set;
      wire en_drop;
      wire flag_keep;
      assign ev = (gi == `VIC_SRC_RESERVED) ? 1'b0 : src_event[gi]; // RULE_01
      assign ack_src = roak_ack && src_st[gi]; // RULE_05
      assign en_set = en_r[gi] | w_en[gi]; // RULE_11
      // Disable beats enable in one access
      assign en_drop = w_dis[gi] | ack_src; // RULE_12 RULE_17 RULE_04 RULE_05
      assign en_nxt[gi] = en_set & ~en_drop; // RULE_11 RULE_17
      assign flag_keep = flag_r[gi] & ~w_clr[gi] & ~ack_src; // RULE_13 RULE_05
      // New event beats any clear
      assign flag_nxt[gi] = ev | flag_keep; // RULE_13
    end
  endgenerate

  // ==========================================================
  // Configuration register
  always @* begin
    cfg_nxt = cfg_r;
    if (wr_cfg) begin
      cfg_nxt = reg_wdata[`VIC_CFG_W-1:0]; // RULE_10
    end
  end

  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cfg_r <= `VIC_CFG_RST; // RULE_15
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  // ==========================================================
  // Source enable and flag registers
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      en_r <= `VIC_EN_RST; // RULE_15
    end else begin
      en_r <= en_nxt;
    end
  end

  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      flag_r <= `VIC_FLAG_RST; // RULE_15
    end else begin
      flag_r <= flag_nxt;
    end
  end

  // ==========================================================
  // Read images
  reg [31:0] ctl_image;
  reg [31:0] cfg_image;

  always @* begin
    ctl_image = `VIC_RD_IDLE; // RULE_12 RULE_14
    ctl_image[`VIC_CTL_EN_LO +: `VIC_NSRC] = en_r; // RULE_11
    ctl_image[`VIC_CTL_CLR_LO +: `VIC_NSRC] = flag_r; // RULE_13
    ctl_image[`VIC_CTL_SRC_LO +: `VIC_NSRC] = src_st; // RULE_14
    ctl_image[`VIC_CTL_IRQ_ST] = bus_req; // RULE_14
    ctl_image[`VIC_CTL_INT_ST] = int_req; // RULE_14
  end

  always @* begin
    cfg_image = `VIC_RD_IDLE;
    cfg_image[`VIC_CFG_W-1:0] = cfg_r; // RULE_10
  end

  // ==========================================================
  // Read select
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = `VIC_RD_IDLE;
    case (reg_addr)
      `VIC_OFS_CFG: begin
        rd_mux = cfg_image; // RULE_10
      end
      `VIC_OFS_CTL: begin
        rd_mux = ctl_image; // RULE_14
      end
      default: begin
        // Unmapped offsets read as zero
        rd_mux = `VIC_RD_IDLE;
      end
    endcase
  end

  // ==========================================================
  // Read data register
  reg [31:0] rdata_nxt;
  always @* begin
    rdata_nxt = reg_rdata_r;
    if (reg_rd_en) begin
      rdata_nxt = rd_mux;
    end
  end

  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      reg_rdata_r <= `VIC_RD_IDLE; // RULE_15
    end else begin
      reg_rdata_r <= rdata_nxt;
    end
  end

  // ==========================================================
  // Acknowledge answer
  reg [7:0] vector_nxt;
  always @* begin
    vector_nxt = iack_vector_r;
    if (ack_hit) begin
      vector_nxt = cfg_vector; // RULE_09
    end
  end

  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      iack_ack_r <= `VIC_ACK_RST;
      iack_pass_r <= `VIC_ACK_RST;
    end else begin
      iack_ack_r <= ack_hit; // RULE_02
      // Miss passes the cycle down the chain
      iack_pass_r <= ack_miss;
    end
  end

  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      iack_vector_r <= `VIC_VEC_RST;
    end else begin
      iack_vector_r <= vector_nxt; // RULE_02 RULE_09
    end
  end

endmodule // vic_vme_interrupter

/* File: testbench/vic_checker.sv */
`timescale 1ns/1ps
// ==========
// Port checks
module vic_checker (
  input sys_clk, reset, reg_wr_en, reg_rd_en, irq_req, iack_req, iack_ack_r, iack_pass_r,
  input [7:0] reg_addr, iack_vector_r,
  input [31:0] reg_wdata, reg_rdata_r,
  input [2:0] irq_level, iack_level
);
  wire cw = reg_wr_en && reg_addr == 8'h08;
  wire cr = reg_rd_en && reg_addr == 8'h0c;
  wire ur = reg_rd_en && reg_addr != 8'h08 && reg_addr != 8'h0c;
  wire hit = iack_req && irq_req && iack_level == irq_level;
  logic [7:0] vec_w;
  always @(posedge sys_clk or posedge reset) begin
    if (reset) vec_w <= 8'h00;
    else if (cw) vec_w <= reg_wdata[7:0];
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  a_ack_hit: assert property (hit |=> iack_ack_r && !iack_pass_r) else $error("ack");
  a_pass_miss: assert property (iack_req && !hit |=> iack_pass_r) else $error("pass");
  a_vec_hold: assert property (!iack_ack_r |-> $stable(iack_vector_r)) else $error("vec");
  a_vec_value: assert property (iack_ack_r |-> iack_vector_r == $past(vec_w))
    else $error("value");
  a_lvl_write: assert property (cw |=> irq_level == $past(reg_wdata[10:8]))
    else $error("level");
  a_gen_off: assert property (cw && !reg_wdata[11] |=> !irq_req) else $error("gen");
  a_unmap_zero: assert property (ur |=> reg_rdata_r == 32'h0) else $error("unmap");
  a_ctl_unused: assert property (cr |=> {reg_rdata_r[25:24], reg_rdata_r[19:4]} == 18'h0)
    else $error("unused");
  a_req_stat: assert property (cr |=> reg_rdata_r[27] == $past(irq_req)
    && reg_rdata_r[26] == |reg_rdata_r[31:28]) else $error("status");
endmodule // vic_checker

bind vic_vme_interrupter vic_checker i_vic_checker (
  .sys_clk(sys_clk), .reset(reset), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
  .irq_req(irq_req), .iack_req(iack_req), .iack_ack_r(iack_ack_r),
  .iack_pass_r(iack_pass_r), .reg_addr(reg_addr), .iack_vector_r(iack_vector_r),
  .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r), .irq_level(irq_level),
  .iack_level(iack_level));

/* File: testbench/vic_master.sv */
`timescale 1ns/1ps
// ==========
// Bus master answering requests
module vic_master (
  input sys_clk, irq_req, iack_ack_r, ak, ms,
  input [2:0] irq_level,
  output logic iack_req = 1'b0,
  output logic [2:0] iack_level = 3'h0
);
  // One cycle per acknowledge; ms answers a foreign level
  always @(posedge sys_clk) begin
    iack_req <= ak && irq_req && !iack_req && !iack_ack_r;
    iack_level <= irq_req ? irq_level ^ {2'b00, ms} : ~iack_level;
  end
endmodule // vic_master

/* File: testbench/test_vme_interrupter_control.sv */
`timescale 1ns/1ps
module test_vme_interrupter_control;
  logic sys_clk = 0, reset = 1, reg_wr_en = 0, reg_rd_en = 0, ak = 0, ms = 0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic [3:0] src_event = 4'h0;
  wire [31:0] reg_rdata_r;
  wire irq_req, iack_req, iack_ack_r, iack_pass_r;
  wire [2:0] irq_level, iack_level;
  wire [7:0] iack_vector_r;
  int miscompares = 0, samples_checked = 0, i;
  logic [71:0] rows [4] = '{{8'h08, 32'hffff_f5a5, 32'h0000_15a5},
    {8'h0c, 32'h0000_000f, 32'h0000_000f}, {8'h0c, 32'h0f0f_fff0, 32'h0000_0000},
    {8'h04, 32'hffff_ffff, 32'h0000_0000}};
  always #10 sys_clk = ~sys_clk;
  vic_vme_interrupter i_vic_vme_interrupter (.sys_clk(sys_clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata),
    .reg_rdata_r(reg_rdata_r), .src_event(src_event), .irq_req(irq_req),
    .irq_level(irq_level), .iack_req(iack_req), .iack_level(iack_level),
    .iack_ack_r(iack_ack_r), .iack_pass_r(iack_pass_r), .iack_vector_r(iack_vector_r));
  vic_master i_vic_master (.sys_clk(sys_clk), .irq_req(irq_req), .iack_ack_r(iack_ack_r),
    .ak(ak), .ms(ms), .irq_level(irq_level), .iack_req(iack_req), .iack_level(iack_level));
  task chk(input string n, input logic [31:0] e, s);
    samples_checked++;
    if (s !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge sys_clk) reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1;
    @(negedge sys_clk) reg_wr_en = 0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(negedge sys_clk) reg_addr = a;
    reg_rd_en = 1;
    @(negedge sys_clk) reg_rd_en = 0;
    chk("rdata", e, reg_rdata_r);
  endtask
  task iack(input logic m, input logic [1:0] e);
    @(negedge sys_clk) ms = m;
    ak = 1;
    for (i = 0; i < 20 && !(iack_ack_r | iack_pass_r); i++) @(negedge sys_clk);
    ak = 0;
    chk("ack_pass", e, {iack_ack_r, iack_pass_r});
  endtask
  task pulse(input logic [3:0] s);
    @(negedge sys_clk) src_event = s;
    @(negedge sys_clk) src_event = 4'h0;
  endtask
  task summarize;
    $display("Compares %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge sys_clk);
    @(negedge sys_clk) reset = 0;
    rd(8'h08, 32'h0);
    rd(8'h0c, 32'h0);
    foreach (rows[k]) begin
      wr(rows[k][71:64], rows[k][63:32]);
      rd(rows[k][71:64], rows[k][31:0]);
    end
    wr(8'h08, 32'h0000_1b5a);
    wr(8'h0c, 32'h0000_0001);
    pulse(4'h1);
    iack(0, 2'b10);
    chk("vector", 32'h5a, iack_vector_r);
    rd(8'h0c, 32'h0);
    wr(8'h08, 32'h0000_0b5a);
    wr(8'h0c, 32'h0000_000d);
    pulse(4'hf);
    iack(1, 2'b01);
    iack(0, 2'b10);
    rd(8'h0c, 32'h9cb0_000d);
    wr(8'h0c, 32'h0009_0000);
    rd(8'h0c, 32'h00b0_0004);
    wr(8'h0c, 32'h00f0_0000);
    rd(8'h0c, 32'h0000_0004);
    // Event and clear in one cycle: the event wins
    @(negedge sys_clk) src_event = 4'h1;
    reg_addr = 8'h0c;
    reg_wdata = 32'h0010_0000;
    reg_wr_en = 1;
    @(negedge sys_clk) src_event = 4'h0;
    reg_wr_en = 0;
    rd(8'h0c, 32'h0010_0004);
    wr(8'h0c, 32'h0001_0001);
    rd(8'h0c, 32'h0010_0004);
    wr(8'h0c, 32'h0000_0001);
    rd(8'h0c, 32'h1c10_0005);
    wr(8'h08, 32'h0000_035a);
    rd(8'h0c, 32'h1410_0005);
    // Reset in mid-run
    @(negedge sys_clk) reset = 1;
    repeat (2) @(negedge sys_clk);
    reset = 0;
    rd(8'h08, 32'h0);
    rd(8'h0c, 32'h0);
    summarize();
  end
endmodule // test_vme_interrupter_control
